/* lmt_pkg.sv */
package lmt_pkg;
    localparam int LINES = 4;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_TEST = 8'h0f;
    localparam logic [7:0] IDX_TALLY_HI = 8'h13;
    localparam logic [7:0] IDX_TALLY_LO = 8'h14;
    localparam logic [7:0] IDX_PORT_SEL = 8'h1c;
    localparam logic [7:0] IDX_STATUS = 8'h1d;

    localparam logic [7:0] TEST_RST = 8'h00;
    localparam logic [7:0] TEST_WMASK = 8'h30;
    localparam int CHAN_SEL_LSB = 4;
    localparam int CHAN_SEL_MSB = 5;
    localparam logic [1:0] PORT_SEL_RST = 2'h0;

    // counting channel select, also the channel tag of received bits
    localparam logic [1:0] BER_OFF = 2'h0;
    localparam logic [1:0] BER_B1 = 2'h1;
    localparam logic [1:0] BER_B2 = 2'h2;
    localparam logic [1:0] BER_D = 2'h3;

    localparam logic [15:0] TALLY_MAX = 16'hffff;

    // control codes on the per-line control channel
    localparam logic [3:0] CI_RESET = 4'h1;
    localparam logic [3:0] CI_PULSE = 4'h5;
    localparam logic [3:0] CI_THRU = 4'h6;
    localparam logic [3:0] CI_ALOOP = 4'h8;

    localparam int CLK_PERIOD_NS = 8;
    localparam int PULSE_PERIOD_NS = 1000000;
    localparam int PULSE_CYCLES = PULSE_PERIOD_NS / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        ST_RESET,
        ST_DEACT,
        ST_ACTIVATING,
        ST_TRANSPARENT
    } lmt_state_t;

    typedef struct packed {
        logic valid;
        logic one;
        logic [1:0] chan;
    } lmt_rx_t;

    typedef struct packed {
        logic wake;
        logic data;
        logic pulse;
    } lmt_tx_t;

    function automatic logic reg_hit(logic [11:0] a, logic [7:0] idx);
        return a == {2'h0, idx, 2'h0};
    endfunction
endpackage

/* lmt_ms_tick.sv */
`timescale 1ns/1ps
module lmt_ms_tick #(
    parameter int PERIOD = 125000
) (
    input wire logic pclk,
    input wire logic presetn,
    output logic tick
);
    localparam int W = $clog2(PERIOD + 1);
    logic [W-1:0] cnt_r;

    // one-cycle enable every PERIOD cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= '0;
            tick <= 1'b0;
        end else if (cnt_r == W'(PERIOD - 1)) begin
            cnt_r <= '0;
            tick <= 1'b1;
        end else begin
            cnt_r <= cnt_r + W'(1);
            tick <= 1'b0;
        end
    end
endmodule

/* lmt_err_tally.sv */
`timescale 1ns/1ps
module lmt_err_tally import lmt_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic inc,
    input wire logic clr,
    input wire logic [15:0] snap,
    output logic [15:0] count
);
    // clear removes what was read; ones counted since the read snapshot stay
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= '0;
        end else if (clr) begin
            count <= count - snap + {15'h0000, inc};
        end else if (inc && count != TALLY_MAX) begin
            count <= count + 16'h0001;
        end
    end
endmodule

/* lmt_ctrl.sv */
`timescale 1ns/1ps
// What this block does
// - port selector picks which line's counter and test register are reached
// - reading the counter low byte clears that line's counter
// - nonzero channel select starts counting on that channel only
// - channel select written zero stops the counter
// - each received one on the selected channel adds one until the count holds at TALLY_MAX; count stays readable
// - single-pulse mode sends one positive pulse per millisecond, nothing else
// - single-pulse pin hits all lines, control code 0101 only its line
// - data-through forces the line state straight to transparent
// - data-through sends normal line signal, no wake-up exchange
// - with data-through pin, reset and analog loop control codes still act; the single-pulse code 0101 does not
// - reset mode sends nothing and holds the line in reset state
// - entering reset mode clears echo canceller and equalizer coefficients
// - a line in reset state refuses activation
// - each line has a 16-bit error counter over B1, B2 and D
// - counter read as high byte then low byte at the next address
// - after reset the test register reads zero, all test modes off
module lmt_ctrl import lmt_pkg::*; #(
    parameter int PULSE_CYC = PULSE_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic single_pulse_test,
    input wire logic data_through_test,
    input wire logic master_reset_request_n,
    input wire logic [LINES-1:0][3:0] ci_code,
    input wire logic [LINES-1:0] act_req,
    input wire logic [LINES-1:0] far_sync,
    input wire lmt_rx_t [LINES-1:0] rx,
    output lmt_tx_t [LINES-1:0] tx,
    output lmt_state_t [LINES-1:0] line_state,
    output logic [LINES-1:0] coef_clr,
    output logic [LINES-1:0] analog_loop
);
    logic [1:0] line_port_selector_r;
    logic [7:0] test_r [LINES];
    logic [15:0] tally [LINES];
    logic [15:0] snap_r;
    logic tick;
    logic [LINES-1:0] rst_m;
    logic [LINES-1:0] pulse_m;
    logic [LINES-1:0] thru_m;
    logic [LINES-1:0] cnt_inc;
    logic [LINES-1:0] clr;
    logic setup;
    logic wr;
    logic rd_lo;
    logic hit;
    logic [7:0] rd_nxt;

    // bus phases: answer registered in setup, so every access is setup plus one wait-free access cycle
    assign setup = psel && !penable;
    assign wr = psel && penable && pready && pwrite;
    assign rd_lo = psel && penable && pready && !pwrite && reg_hit(paddr, IDX_TALLY_LO);

    // read decode against the selected line bank
    always_comb begin
        rd_nxt = 8'h00;
        hit = 1'b1;
        if (reg_hit(paddr, IDX_TEST)) begin
            rd_nxt = test_r[line_port_selector_r];
        end else if (reg_hit(paddr, IDX_TALLY_HI)) begin
            rd_nxt = tally[line_port_selector_r][15:8];
        end else if (reg_hit(paddr, IDX_TALLY_LO)) begin
            rd_nxt = tally[line_port_selector_r][7:0];
        end else if (reg_hit(paddr, IDX_PORT_SEL)) begin
            rd_nxt = {6'h00, line_port_selector_r};
        end else if (reg_hit(paddr, IDX_STATUS)) begin
            rd_nxt = {3'h0, analog_loop[line_port_selector_r], thru_m[line_port_selector_r],
                pulse_m[line_port_selector_r], line_state[line_port_selector_r]};
        end else begin
            hit = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
            snap_r <= 16'h0000;
        end else begin
            pready <= setup;
            if (setup) begin
                prdata <= {24'h000000, rd_nxt};
                pslverr <= !hit;
                snap_r <= tally[line_port_selector_r];
            end
        end
    end

    a_test_read:
    assert property (@(posedge pclk) disable iff (!presetn)
        setup && reg_hit(paddr, IDX_TEST)
        |=> prdata[7:0] == $past(test_r[line_port_selector_r]))
    else $error("test register read from wrong line");

    a_hi_read:
    assert property (@(posedge pclk) disable iff (!presetn)
        setup && reg_hit(paddr, IDX_TALLY_HI)
        |=> prdata == {24'h000000, $past(tally[line_port_selector_r][15:8])})
    else $error("counter high byte read wrong");

    a_lo_read:
    assert property (@(posedge pclk) disable iff (!presetn)
        setup && reg_hit(paddr, IDX_TALLY_LO)
        |=> prdata == {24'h000000, $past(tally[line_port_selector_r][7:0])})
    else $error("counter low byte read wrong");

    a_sel_write:
    assert property (@(posedge pclk) disable iff (!presetn)
        wr && reg_hit(paddr, IDX_PORT_SEL) |=> line_port_selector_r == $past(pwdata[1:0]))
    else $error("port selector write not taken");

    // port selector
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_port_selector_r <= PORT_SEL_RST;
        end else if (wr && reg_hit(paddr, IDX_PORT_SEL)) begin
            line_port_selector_r <= pwdata[1:0];
        end
    end

    // per-line test registers, only the counting channel field is writable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < LINES; i++) begin
                test_r[i] <= TEST_RST;
            end
        end else if (wr && reg_hit(paddr, IDX_TEST)) begin
            test_r[line_port_selector_r] <= pwdata[7:0] & TEST_WMASK;
        end
    end

    lmt_ms_tick #(
        .PERIOD(PULSE_CYC)
    ) u_tick (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick)
    );

    for (genvar g = 0; g < LINES; g++) begin : g_line
        logic [1:0] sel;
        assign sel = test_r[g][CHAN_SEL_MSB:CHAN_SEL_LSB];
        assign rst_m[g] = !master_reset_request_n || ci_code[g] == CI_RESET;
        assign pulse_m[g] = single_pulse_test || ci_code[g] == CI_PULSE;
        assign thru_m[g] = data_through_test || ci_code[g] == CI_THRU;
        assign cnt_inc[g] = sel != BER_OFF && rx[g].valid && rx[g].one
            && rx[g].chan == sel;
        assign clr[g] = rd_lo && line_port_selector_r == 2'(g);

        lmt_err_tally u_tally (
            .pclk(pclk),
            .presetn(presetn),
            .inc(cnt_inc[g]),
            .clr(clr[g]),
            .snap(snap_r),
            .count(tally[g])
        );

        sequence s_pulse_on;
            pulse_m[g] && !rst_m[g] && !thru_m[g];
        endsequence

        sequence s_enter_rst;
            rst_m[g] && line_state[g] != ST_RESET;
        endsequence

        a_coef_clear:
        assert property (@(posedge pclk) disable iff (!presetn)
            s_enter_rst |=> coef_clr[g] && line_state[g] == ST_RESET ##1 !coef_clr[g])
        else $error("coefficient clear not a single pulse on reset entry");

        a_reset_quiet:
        assert property (@(posedge pclk) disable iff (!presetn)
            rst_m[g] |=> line_state[g] == ST_RESET && tx[g] == 3'h0)
        else $error("line not silent in reset state");

        a_thru_transp:
        assert property (@(posedge pclk) disable iff (!presetn)
            thru_m[g] && !rst_m[g] |=> line_state[g] == ST_TRANSPARENT)
        else $error("data-through did not force transparent state");

        a_thru_no_wake:
        assert property (@(posedge pclk) disable iff (!presetn)
            thru_m[g] && !rst_m[g] |=> tx[g].data && !tx[g].wake)
        else $error("data-through line signal wrong");

        a_pulse_gap:
        assert property (@(posedge pclk) disable iff (!presetn)
            s_pulse_on ##0 !tick |=> tx[g] == 3'h0)
        else $error("signal sent between single pulses");

        a_pulse_pin:
        assert property (@(posedge pclk) disable iff (!presetn)
            single_pulse_test && !rst_m[g] && !thru_m[g] && tick |=> tx[g] == 3'h1)
        else $error("pin did not give a pulse on this line");

        a_no_activate:
        assert property (@(posedge pclk) disable iff (!presetn)
            line_state[g] == ST_RESET && act_req[g] && !thru_m[g]
            |=> line_state[g] == ST_RESET || line_state[g] == ST_DEACT)
        else $error("activation taken from reset state");

        a_stop_hold:
        assert property (@(posedge pclk) disable iff (!presetn)
            sel == BER_OFF && !clr[g] |=> $stable(tally[g]))
        else $error("counter moved while stopped");

        a_count_one:
        assert property (@(posedge pclk) disable iff (!presetn)
            cnt_inc[g] && !clr[g] && tally[g] != TALLY_MAX
            |=> tally[g] == 16'($past(tally[g]) + 16'h0001))
        else $error("received one not counted");

        a_clear_read:
        assert property (@(posedge pclk) disable iff (!presetn)
            clr[g] && !cnt_inc[g] |=> tally[g] == 16'($past(tally[g]) - $past(snap_r)))
        else $error("low byte read did not clear counter");

        a_test_write:
        assert property (@(posedge pclk) disable iff (!presetn)
            wr && reg_hit(paddr, IDX_TEST) && line_port_selector_r == 2'(g)
            |=> test_r[g] == ($past(pwdata[7:0]) & TEST_WMASK))
        else $error("channel select write not taken");

        a_only_chosen:
        assert property (@(posedge pclk) disable iff (!presetn)
            rx[g].valid && rx[g].one && rx[g].chan != sel && !clr[g] |=> $stable(tally[g]))
        else $error("one on unselected channel counted");

        a_pulse_code:
        assert property (@(posedge pclk) disable iff (!presetn)
            ci_code[g] == CI_PULSE && !rst_m[g] && !thru_m[g] && tick |=> tx[g].pulse)
        else $error("control code did not give a pulse");

        a_pulse_on_tick:
        assert property (@(posedge pclk) disable iff (!presetn)
            tx[g].pulse |-> $past(tick))
        else $error("pulse sent off the millisecond tick");

        a_thru_loop:
        assert property (@(posedge pclk) disable iff (!presetn)
            data_through_test && ci_code[g] == CI_ALOOP && !rst_m[g] |=> analog_loop[g])
        else $error("analog loop ignored under data-through pin");

        a_loop_reset:
        assert property (@(posedge pclk) disable iff (!presetn)
            rst_m[g] |=> !analog_loop[g])
        else $error("analog loop left on in reset mode");

        a_code_release:
        assert property (@(posedge pclk) disable iff (!presetn)
            ci_code[g] != CI_ALOOP |=> !analog_loop[g])
        else $error("analog loop outlived its control code");
    end

    // line state: reset mode first, then data-through, then normal progress
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < LINES; i++) begin
                line_state[i] <= ST_RESET;
            end
        end else begin
            for (int i = 0; i < LINES; i++) begin
                if (rst_m[i]) begin
                    line_state[i] <= ST_RESET;
                end else if (thru_m[i]) begin
                    line_state[i] <= ST_TRANSPARENT;
                end else begin
                    case (line_state[i])
                        ST_RESET: begin
                            line_state[i] <= ST_DEACT;
                        end
                        ST_DEACT: begin
                            if (act_req[i]) begin
                                line_state[i] <= ST_ACTIVATING;
                            end
                        end
                        ST_ACTIVATING: begin
                            if (!act_req[i]) begin
                                line_state[i] <= ST_DEACT;
                            end else if (far_sync[i]) begin
                                line_state[i] <= ST_TRANSPARENT;
                            end
                        end
                        default: begin
                            if (!act_req[i]) begin
                                line_state[i] <= ST_DEACT;
                            end
                        end
                    endcase
                end
            end
        end
    end

    // coefficient clear pulse on entry into reset state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            coef_clr <= '0;
        end else begin
            for (int i = 0; i < LINES; i++) begin
                coef_clr[i] <= rst_m[i] && line_state[i] != ST_RESET;
            end
        end
    end

    // line transmit control per line
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx <= '0;
        end else begin
            for (int i = 0; i < LINES; i++) begin
                tx[i].pulse <= !rst_m[i] && !thru_m[i] && pulse_m[i] && tick;
                tx[i].data <= !rst_m[i] && (thru_m[i] || (!pulse_m[i]
                    && line_state[i] == ST_TRANSPARENT));
                tx[i].wake <= !rst_m[i] && !thru_m[i] && !pulse_m[i]
                    && line_state[i] == ST_ACTIVATING;
            end
        end
    end

    // analog loop request stays live under data-through pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            analog_loop <= '0;
        end else begin
            for (int i = 0; i < LINES; i++) begin
                analog_loop[i] <= !rst_m[i] && ci_code[i] == CI_ALOOP;
            end
        end
    end
endmodule

/* lmt_partner.sv */
`timescale 1ns/1ps
module lmt_partner import lmt_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    input wire lmt_tx_t [LINES-1:0] tx,
    input wire logic loop_closed,
    input wire logic [LINES-1:0] inject,
    input wire logic [LINES-1:0][1:0] inj_chan,
    output lmt_rx_t [LINES-1:0] rx,
    output logic [LINES-1:0] far_sync
);
    logic [LINES-1:0][5:0] wake_cnt_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_cnt_r <= '0;
        end else begin
            for (int i = 0; i < LINES; i++) begin
                if (tx[i] == 3'h0) begin
                    wake_cnt_r[i] <= 6'h0;
                end else if (tx[i].wake && wake_cnt_r[i] != 6'h3f) begin
                    wake_cnt_r[i] <= wake_cnt_r[i] + 6'h1;
                end
            end
        end
    end
    // line i syncs after 2 + 9*i wake cycles: prompt to slow
    always_comb begin
        for (int i = 0; i < LINES; i++) begin
            far_sync[i] = wake_cnt_r[i] >= 6'(2 + 9 * i);
            rx[i].valid = 1'b1;
            rx[i].one = inject[i] & loop_closed;
            rx[i].chan = inj_chan[i];
        end
    end
endmodule

/* lmt_ctrl_test.sv */
`timescale 1ns/1ps
module lmt_ctrl_test import lmt_pkg::*;;
    localparam int PC = 8;
    localparam logic [11:0] A_TEST = 12'h03c, A_HI = 12'h04c, A_LO = 12'h050;
    localparam logic [11:0] A_SEL = 12'h070, A_STAT = 12'h074, A_NONE = 12'h200;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, er;
    logic pulse_pin = 0, thru_pin = 0, hold_pin_n = 1, loop_closed = 0;
    logic [LINES-1:0][3:0] ci_code = '0;
    logic [LINES-1:0] act_req = '0, inject = '0;
    logic [LINES-1:0] far_sync, coef_clr, analog_loop;
    logic [LINES-1:0][1:0] inj_chan = '0;
    lmt_rx_t [LINES-1:0] rx;
    lmt_tx_t [LINES-1:0] tx;
    lmt_state_t [LINES-1:0] line_state;
    logic [3:0] codes [3] = '{4'h6, 4'h5, 4'h1};
    logic [1:0] c;
    int n_errors = 0, samples_checked = 0, l, n, cc, wk, ex;
    integer seed = 32'hd2d76979;
    always #4 pclk = ~pclk;
    lmt_ctrl #(.PULSE_CYC(PC)) DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .single_pulse_test(pulse_pin), .data_through_test(thru_pin),
        .master_reset_request_n(hold_pin_n), .ci_code(ci_code), .act_req(act_req),
        .far_sync(far_sync), .rx(rx), .tx(tx), .line_state(line_state),
        .coef_clr(coef_clr), .analog_loop(analog_loop));
    lmt_partner far_end (.pclk(pclk), .presetn(presetn), .tx(tx), .loop_closed(loop_closed),
        .inject(inject), .inj_chan(inj_chan), .rx(rx), .far_sync(far_sync));
    task automatic stop_test;
        if (n_errors == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic int hit(input logic [1:0] ch, input logic [1:0] f);
        return (f != 2'h0 && ch == f) ? 1 : 0;
    endfunction
    function automatic lmt_state_t mode_state(input logic [3:0] code);
        return (code == 4'h1) ? ST_RESET : ST_TRANSPARENT;
    endfunction
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] d, output logic r);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        d = prdata;
        r = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic r;
        apb(1'b0, a, 32'h0, d, r);
        chk(d, e);
    endtask
    task automatic chk_pulses(input logic [LINES-1:0] on);
        int pc [LINES];
        int bad;
        bad = 0;
        foreach (pc[i]) pc[i] = 0;
        repeat (8 * PC) begin
            @(posedge pclk);
            for (int i = 0; i < LINES; i++) begin
                pc[i] += tx[i].pulse;
                bad += tx[i].wake | tx[i].data;
            end
        end
        for (int i = 0; i < LINES; i++) chk(pc[i], on[i] ? 8 : 0);
        chk(bad, 0);
    endtask
    initial begin
        #(8 * 30000);
        n_errors++;
        stop_test;
    end
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd_chk(A_TEST, 32'h0);
        rd_chk(A_SEL, 32'h0);
        rd_chk(A_HI, 32'h0);
        rd_chk(A_STAT, 32'h1);
        apb(1'b0, A_NONE, 32'h0, rd, er);
        chk(rd, 32'h0);
        chk(er, 1'b1);
        loop_closed <= 1'b1;
        for (int k = 1; k < 4; k++) begin
            l = $unsigned($random(seed)) % LINES;
            apb(1'b1, A_SEL, l, rd, er);
            rd_chk(A_SEL, l);
            apb(1'b0, A_LO, 32'h0, rd, er);
            apb(1'b1, A_TEST, ($random(seed) & 32'hcf) | (k << 4), rd, er);
            rd_chk(A_TEST, k << 4);
            ex = 0;
            repeat (600) begin
                c = $random(seed) & 1 ? 2'(k) : 2'($random(seed));
                ex += hit(c, 2'(k));
                inject[l] <= 1'b1;
                inj_chan[l] <= c;
                @(posedge pclk);
            end
            inject[l] <= 1'b0;
            apb(1'b1, A_TEST, 32'h0, rd, er);
            inject[l] <= 1'b1;
            inj_chan[l] <= 2'(k);
            repeat (10) @(posedge pclk);
            inject[l] <= 1'b0;
            rd_chk(A_HI, ex >> 8);
            rd_chk(A_LO, ex & 8'hff);
            rd_chk(A_LO, 32'h0);
        end
        l = $unsigned($random(seed)) % LINES;
        act_req[l] <= 1'b1;
        for (int k = 0; k < 3; k++) begin
            ci_code[l] <= codes[k];
            cc = 0;
            repeat (3) begin
                @(posedge pclk);
                cc += coef_clr[l];
            end
            chk(cc, codes[k] == 4'h1);
            if (codes[k] == 4'h5) begin
                chk_pulses(4'h1 << l);
            end else begin
                chk(line_state[l], mode_state(codes[k]));
                chk(tx[l], codes[k] == 4'h1 ? 3'h0 : 3'h2);
            end
        end
        ci_code[l] <= 4'h0;
        wk = 0;
        n = 0;
        while (line_state[l] !== ST_TRANSPARENT && n < 200) begin
            @(posedge pclk);
            wk += tx[l].wake;
            n++;
        end
        chk(line_state[l], ST_TRANSPARENT);
        chk(wk != 0, 1'b1);
        act_req <= '0;
        pulse_pin <= 1'b1;
        ci_code[l] <= 4'h5;
        repeat (3) @(posedge pclk);
        chk_pulses(4'hf);
        thru_pin <= 1'b1;
        ci_code[l] <= 4'h8;
        repeat (3) @(posedge pclk);
        chk(analog_loop, 4'h1 << l);
        apb(1'b1, A_SEL, l, rd, er);
        rd_chk(A_STAT, 32'h1f);
        for (int i = 0; i < LINES; i++) begin
            chk(line_state[i], ST_TRANSPARENT);
            chk(tx[i], 3'h2);
        end
        hold_pin_n <= 1'b0;
        repeat (3) @(posedge pclk);
        chk(analog_loop, 4'h0);
        for (int i = 0; i < LINES; i++) begin
            chk(line_state[i], ST_RESET);
            chk(tx[i], 3'h0);
        end
        stop_test;
    end
endmodule
